// file: dzts_pkg.sv
package dzts_pkg;

  // Scheme selection
  typedef enum logic [1:0] {
    DZTS_SCH_STEP = 2'b00,
    DZTS_SCH_EXT = 2'b01,
    DZTS_SCH_PILOT = 2'b10,
    DZTS_SCH_SPARE = 2'b11
  } dzts_scheme_e;

  // Recloser state as reported by the recloser function
  typedef enum logic [1:0] {
    DZTS_RC_RESET = 2'b00,
    DZTS_RC_CYCLE = 2'b01,
    DZTS_RC_STATE_A = 2'b10,
    DZTS_RC_SPARE = 2'b11
  } dzts_rc_e;

  // Second-zone ground directional overcurrent use
  typedef enum logic [1:0] {
    DZTS_GD_OFF = 2'b00,
    DZTS_GD_REPLACE = 2'b01,
    DZTS_GD_SUPPLEMENT = 2'b10,
    DZTS_GD_SPARE = 2'b11
  } dzts_gdoc_e;

  // Zone and element counts, and zone indexes
  localparam int DZTS_ZONES = 4;
  localparam int DZTS_PHASES = 3;
  localparam int DZTS_TIMED = 3;
  localparam int DZTS_Z1 = 0;
  localparam int DZTS_Z2 = 1;
  localparam int DZTS_Z4 = 3;
  // Default timer width in bits
  localparam int DZTS_TW = 16;
  // Recommended stretch dropout for contacts that already mimic the flag
  localparam int DZTS_STRETCH_NONE = 0;

endpackage : dzts_pkg

// file: dzts_stretch.sv
module dzts_stretch #(
  parameter int TW = dzts_pkg::DZTS_TW
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire logic contact_pin,
  input wire logic [TW-1:0] dropout_ticks,
  output logic stretched
);
  import dzts_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic [TW-1:0] cnt;
    logic out;
  } dzts_st_s;

  dzts_st_s st_q;
  dzts_st_s st_d;

  if (TW < 2) begin : g_chk
    $error("dzts_stretch: TW too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Three-stage pin sync, stretch on the common tick
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = contact_pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // Level changes only once stages two and three agree
    if (st_q.s2 == st_q.s3)
      st_d.level = st_q.s3;
    if (tick)
    begin
      if (st_q.level)
        st_d.cnt = dropout_ticks; // RQ8
      else if (st_q.cnt != '0)
        st_d.cnt = st_q.cnt - 1'b1; // RQ8
      // Zero dropout passes the contact straight through
      st_d.out = st_q.level | (st_q.cnt != '0); // RQ8
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      st_q <= '0;
    else if (ce)
      st_q <= st_d;
  end

  assign stretched = st_q.out;

  // A closed contact always shows on the next tick
  a_stretch_follow: assert property (@(posedge mclk) disable iff (!rst_n) // RQ8
    ce && tick && st_q.level |=> stretched)
    else $error("stretch output missed an asserted contact");

  // Once the dropout count is spent the output falls
  a_stretch_drop: assert property (@(posedge mclk) disable iff (!rst_n) // RQ8
    ce && tick && !st_q.level && st_q.cnt == '0 |=> !stretched)
    else $error("stretch output held past dropout");

endmodule : dzts_stretch

// file: dzts_core.sv
// Operation
// RQ1: Extension scheme, no reclose running: second zone trips instantly for first.
// RQ2: Reclose cycle started: true first zone is instant source until reset.
// RQ3: Reach-reset flag sets on recloser initiate, clears on entering reset.
// RQ4: Recloser_state_a keeps flag set until recloser later reaches reset.
// RQ5: Reach-reset contact closed exactly while the flag is set.
// RQ6: Internal recloser: flag picks instant source; contact input unused.
// RQ7: No internal recloser: external contact input replaces the flag.
// RQ8: Contact input passes a stretch timer with settable dropout.
// RQ9: During reclaim a persisting fault trips as plain step distance.
// RQ10: Step distance logic runs under every selected scheme.
// RQ11: Per zone, separate in-service settings for phase and ground.
// RQ12: Zones two to four each have phase and ground delay timers.
// RQ13: Six measuring elements per zone: three phase, three ground.
// RQ14: Fourth zone direction reversible; pilot blocking schemes need reverse.
// RQ15: Optional reactance ground with mho supervision for first-zone ground.
// RQ16: Ground directional overcurrent replaces or supplements zone-two ground.
// RQ17: Backup: phase instant, ground instant and timed with direction option.
// RQ18: Every trip is gated by the fault detector; the code gates only trip, not instant_trip, timed_trip or backup_trip.
// RQ19: Timers, stretch and flag advance on one common processing tick.
module dzts_core #(
  parameter int TW = dzts_pkg::DZTS_TW
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tick,
  input wire dzts_pkg::dzts_scheme_e scheme_sel,
  input wire logic recloser_internal,
  input wire logic recloser_initiate,
  input wire dzts_pkg::dzts_rc_e recloser_state,
  input wire logic recloser_contact_input,
  input wire logic [TW-1:0] stretch_dropout,
  input wire logic [3:0] zone_phase_en,
  input wire logic [3:0] zone_ground_en,
  input wire logic [3:0][2:0] phase_meas,
  input wire logic [3:0][2:0] ground_meas,
  input wire logic z1_reactance_sel,
  input wire logic [2:0] z1_reactance_meas,
  input wire logic [2:0] z1_adaptive_mho,
  input wire dzts_pkg::dzts_gdoc_e z2_gdoc_mode,
  input wire logic z2_gdoc_trip,
  input wire logic z4_reverse_set,
  input wire logic [2:0][TW-1:0] phase_delay,
  input wire logic [2:0][TW-1:0] ground_delay,
  input wire logic phase_instant_backup,
  input wire logic ground_instant_backup,
  input wire logic ground_instant_dir_en,
  input wire logic ground_timed_backup,
  input wire logic ground_timed_dir_en,
  input wire logic ground_dir_forward,
  input wire logic fault_detector,
  output logic trip,
  output logic instant_trip,
  output logic [2:0] timed_trip,
  output logic backup_trip,
  output logic reach_reset_contact,
  output logic reach_select_gate,
  output logic z4_reverse,
  output logic scheme_conflict
);
  import dzts_pkg::*;

  typedef struct packed {
    logic flag;
    logic was_reset;
    logic [2:0][TW-1:0] ph_cnt;
    logic [2:0][TW-1:0] gd_cnt;
    logic trip;
    logic inst;
    logic [2:0] timed;
    logic backup;
    logic sel;
    logic z4rev;
    logic conflict;
  } dzts_core_s;

  dzts_core_s st_q;
  dzts_core_s st_d;

  logic contact_stretched;
  logic tick_en;
  logic [3:0] ph_pu;
  logic [3:0] gd_pu;
  logic first_zone_trip_gate;
  logic gnd_z1;
  logic gnd_z2;
  logic [2:0] ph_done;
  logic [2:0] gd_done;
  logic bk;

  if (TW < 2) begin : g_chk
    $error("dzts_core: TW too small");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Saturating zone timer: counts ticks while its element stays picked up
  function automatic logic [TW-1:0] timer_next(input logic pu, input logic [TW-1:0] cnt);
    if (!pu)
      return '0;
    else if (cnt == '1)
      return cnt;
    else
      return cnt + 1'b1;
  endfunction : timer_next

  // Timer output: a zero setting operates on the pickup itself
  function automatic logic timer_done(input logic pu, input logic [TW-1:0] cnt,
                                      input logic [TW-1:0] set);
    return pu && (cnt >= set);
  endfunction : timer_done

  ////////////////////////////////////////////////////////////////////////////
  // External contact path, only consulted without the internal recloser
  dzts_stretch #(
    .TW(TW)
  ) u_recloser_contact_stretch_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .ce(ce),
    .tick(tick),
    .contact_pin(recloser_contact_input),
    .dropout_ticks(stretch_dropout),
    .stretched(contact_stretched)
  );

  assign tick_en = ce & tick; // RQ19

  ////////////////////////////////////////////////////////////////////////////
  // Zone element pickups with enables and optional substitutions
  always_comb
  begin
    // Reactance ground needs its adaptive mho supervision in the same phase
    gnd_z1 = z1_reactance_sel ? |(z1_reactance_meas & z1_adaptive_mho)
                              : |ground_meas[DZTS_Z1]; // RQ15
    case (z2_gdoc_mode)
      DZTS_GD_REPLACE: gnd_z2 = z2_gdoc_trip; // RQ16
      DZTS_GD_SUPPLEMENT: gnd_z2 = z2_gdoc_trip | (|ground_meas[DZTS_Z2]); // RQ16
      default: gnd_z2 = |ground_meas[DZTS_Z2];
    endcase
    for (int z = 0; z < DZTS_ZONES; z++)
    begin
      // Any of the three phase-pair or three phase-ground elements
      ph_pu[z] = zone_phase_en[z] & (|phase_meas[z]); // RQ11 RQ13
      gd_pu[z] = zone_ground_en[z] & (|ground_meas[z]); // RQ11 RQ13
    end
    gd_pu[DZTS_Z1] = zone_ground_en[DZTS_Z1] & gnd_z1; // RQ11
    gd_pu[DZTS_Z2] = zone_ground_en[DZTS_Z2] & gnd_z2; // RQ11
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instantaneous source and step-distance timed outputs
  always_comb
  begin
    // Flag with internal recloser, stretched contact otherwise
    reach_select_gate = recloser_internal ? st_q.flag : contact_stretched; // RQ6 RQ7
    // Extension: second zone stands in until a reclose cycle is seen
    if (scheme_sel == DZTS_SCH_EXT && !reach_select_gate)
      first_zone_trip_gate = ph_pu[DZTS_Z2] | gd_pu[DZTS_Z2]; // RQ1
    else
      first_zone_trip_gate = ph_pu[DZTS_Z1] | gd_pu[DZTS_Z1]; // RQ2 RQ9
    for (int t = 0; t < DZTS_TIMED; t++)
    begin
      ph_done[t] = timer_done(ph_pu[t+1], st_q.ph_cnt[t], phase_delay[t]); // RQ12
      gd_done[t] = timer_done(gd_pu[t+1], st_q.gd_cnt[t], ground_delay[t]); // RQ12
    end
    // Directional control only when enabled for each ground backup
    bk = phase_instant_backup
       | (ground_instant_backup & (!ground_instant_dir_en | ground_dir_forward))
       | (ground_timed_backup & (!ground_timed_dir_en | ground_dir_forward)); // RQ17
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state: flag, timers and registered trip outputs, per tick
  always_comb
  begin
    st_d = st_q;
    if (tick_en)
    begin
      st_d.was_reset = (recloser_state == DZTS_RC_RESET);
      // Clear only on entry to reset, so recloser_state_a holds the flag
      if (recloser_state == DZTS_RC_RESET && !st_q.was_reset)
        st_d.flag = 1'b0; // RQ3 RQ4
      // Initiate in the same tick wins over the clear
      if (recloser_initiate)
        st_d.flag = 1'b1; // RQ3
      for (int t = 0; t < DZTS_TIMED; t++)
      begin
        st_d.ph_cnt[t] = timer_next(ph_pu[t+1], st_q.ph_cnt[t]); // RQ12 RQ19
        st_d.gd_cnt[t] = timer_next(gd_pu[t+1], st_q.gd_cnt[t]); // RQ12 RQ19
        st_d.timed[t] = ph_done[t] | gd_done[t];
      end
      st_d.inst = first_zone_trip_gate;
      st_d.backup = bk;
      st_d.sel = reach_select_gate;
      // Step distance trips sit under every scheme; trip never leaves without FD
      st_d.trip = fault_detector & (first_zone_trip_gate | (|(ph_done | gd_done)) | bk); // RQ10 RQ18
      st_d.z4rev = z4_reverse_set; // RQ14
      st_d.conflict = (scheme_sel == DZTS_SCH_PILOT) & !z4_reverse_set; // RQ14
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      st_q <= '0;
    else if (ce)
      st_q <= st_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs from flops; reach_select_gate is a combinational mux
  assign trip = st_q.trip;
  assign instant_trip = st_q.inst;
  assign timed_trip = st_q.timed;
  assign backup_trip = st_q.backup;
  assign reach_reset_contact = st_q.flag; // RQ5
  assign z4_reverse = st_q.z4rev;
  assign scheme_conflict = st_q.conflict;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  // Initiate always closes the reach-reset contact on the next tick
  a_flag_on_init: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
    tick_en && recloser_initiate |=> reach_reset_contact)
    else $error("flag not set by recloser initiate");

  // Entry into reset opens it unless an initiate comes in the same tick
  a_flag_clear_entry: assert property (@(posedge mclk) disable iff (!rst_n) // RQ3
    tick_en && !recloser_initiate && recloser_state == DZTS_RC_RESET && !st_q.was_reset
    |=> !reach_reset_contact)
    else $error("flag not cleared on entering reset");

  // Recloser_state_a must not drop the flag, or zone two would overreach again
  a_flag_hold_lock: assert property (@(posedge mclk) disable iff (!rst_n) // RQ4
    tick_en && reach_reset_contact && recloser_state == DZTS_RC_STATE_A
    |=> reach_reset_contact)
    else $error("flag dropped during recloser_state_a");

  // The contact has no source other than the initiate
  a_contact_rise: assert property (@(posedge mclk) disable iff (!rst_n) // RQ5
    $rose(reach_reset_contact) |-> $past(tick_en) && $past(recloser_initiate))
    else $error("contact closed without initiate");

  // Extension with no reclose seen: zone two is the instant source
  a_ext_z2_instant: assert property (@(posedge mclk) disable iff (!rst_n) // RQ1
    tick_en && scheme_sel == DZTS_SCH_EXT && !reach_select_gate && ph_pu[DZTS_Z2]
    |=> instant_trip)
    else $error("second zone not instantaneous in extension");

  // With the reach reset, only zone one may trip instantly
  a_restored_z1: assert property (@(posedge mclk) disable iff (!rst_n) // RQ2
    tick_en && reach_select_gate && !ph_pu[DZTS_Z1] && !gd_pu[DZTS_Z1]
    |=> !instant_trip)
    else $error("instant trip without first zone after reach reset");

  // Without the internal recloser a quiet stretched contact keeps zone two instant
  a_ext_contact_sel: assert property (@(posedge mclk) disable iff (!rst_n) // RQ7
    tick_en && !recloser_internal && scheme_sel == DZTS_SCH_EXT && !contact_stretched
    && (ph_pu[DZTS_Z2] || gd_pu[DZTS_Z2]) |=> instant_trip)
    else $error("external contact not used for reach select");

  // Trip rises only after a tick that saw the fault detector
  a_trip_fd_gate: assert property (@(posedge mclk) disable iff (!rst_n) // RQ18
    $rose(trip) |-> $past(fault_detector))
    else $error("trip without fault detector");

  // trip stays low after a tick without the fault detector
  a_no_fd_trip: assert property (@(posedge mclk) disable iff (!rst_n) // RQ18
    tick_en && !fault_detector |=> !trip)
    else $error("trip issued without fault detector");

  // A zero delay operates on the pickup itself
  a_timer_zero: assert property (@(posedge mclk) disable iff (!rst_n) // RQ12
    tick_en && fault_detector && ph_pu[DZTS_Z4] && phase_delay[2] == '0
    |=> trip && timed_trip[2])
    else $error("zero-delay zone four phase timer did not trip");

  // Dropping the zone two pickups restarts its timers
  a_timer_restart: assert property (@(posedge mclk) disable iff (!rst_n) // RQ12
    tick_en && !ph_pu[DZTS_Z2] && !gd_pu[DZTS_Z2] |=> !timed_trip[0])
    else $error("zone two timer output without pickup");

  // Outside extension, zone one out of service in both halves gives no instant trip
  a_zone_out: assert property (@(posedge mclk) disable iff (!rst_n) // RQ11
    tick_en && scheme_sel != DZTS_SCH_EXT && zone_phase_en[DZTS_Z1] == 1'b0
    && zone_ground_en[DZTS_Z1] == 1'b0 |=> !instant_trip)
    else $error("instant trip from a zone out of service");

  // Backup trips need no zone pickup
  a_backup_trip: assert property (@(posedge mclk) disable iff (!rst_n) // RQ17
    tick_en && fault_detector && phase_instant_backup |=> trip && backup_trip)
    else $error("phase backup did not trip");

  // A pilot scheme with a forward fourth zone is reported, not blocked
  a_pilot_conflict: assert property (@(posedge mclk) disable iff (!rst_n) // RQ14
    tick_en && scheme_sel == DZTS_SCH_PILOT && !z4_reverse_set |=> scheme_conflict)
    else $error("pilot scheme with forward zone four not reported");

  // Between ticks, or while ce is low, the registered outputs must stand
  a_hold_off_tick: assert property (@(posedge mclk) disable iff (!rst_n) // RQ19
    !tick_en |=> $stable(trip) && $stable(timed_trip) && $stable(reach_reset_contact))
    else $error("outputs moved without a tick");

endmodule : dzts_core

// file: dzts_recl_model.sv
module dzts_recl_model (
  input wire logic mclk,
  input wire logic [1:0] cmd,
  output logic initiate,
  output dzts_pkg::dzts_rc_e state,
  output logic contact_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  import dzts_pkg::*;

  // Breaker closed, recloser idle at power up
  initial
  begin
    initiate = 1'b0;
    state = DZTS_RC_RESET;
    contact_pin = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Code 1 trips the breaker and starts a cycle, 2 ends in recloser_state_a,
  // 3 is a manual close that times out to reset; other codes hold the state.
  // The contact is momentary, like a cheap recloser, so the stretch
  // timer has to carry it through the reclaim time.
  always @(posedge mclk)
  begin
    initiate <= (cmd == 2'h1);
    contact_pin <= (cmd == 2'h1);
    case (cmd)
      2'h1: state <= DZTS_RC_CYCLE;
      2'h2: state <= DZTS_RC_STATE_A;
      2'h3: state <= DZTS_RC_RESET;
      default: state <= state;
    endcase
  end
endmodule : dzts_recl_model

// file: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dzts_pkg::*;

  // Short timers keep the run brief
  localparam int TW = 4;
  logic mclk, rst_n, ce, tick, recloser_internal, recloser_initiate;
  logic recloser_contact_input, z1_reactance_sel, z2_gdoc_trip, z4_reverse_set;
  logic phase_instant_backup, ground_instant_backup, ground_instant_dir_en;
  logic ground_timed_backup, ground_timed_dir_en, ground_dir_forward, fault_detector;
  logic trip, instant_trip, backup_trip, reach_reset_contact, reach_select_gate;
  logic z4_reverse, scheme_conflict;
  logic [TW-1:0] stretch_dropout;
  logic [3:0] zone_phase_en, zone_ground_en;
  logic [3:0][2:0] phase_meas, ground_meas;
  logic [2:0] z1_reactance_meas, z1_adaptive_mho, timed_trip;
  logic [2:0][TW-1:0] phase_delay, ground_delay;
  logic [1:0] rc_cmd;
  dzts_scheme_e scheme_sel;
  dzts_rc_e recloser_state;
  dzts_gdoc_e z2_gdoc_mode;
  int mismatches, check_count;

  dzts_core #(.TW(TW)) dut_u (.mclk, .rst_n, .ce, .tick, .scheme_sel, .recloser_internal,
    .recloser_initiate, .recloser_state, .recloser_contact_input, .stretch_dropout,
    .zone_phase_en, .zone_ground_en, .phase_meas, .ground_meas, .z1_reactance_sel,
    .z1_reactance_meas, .z1_adaptive_mho, .z2_gdoc_mode, .z2_gdoc_trip, .z4_reverse_set,
    .phase_delay, .ground_delay, .phase_instant_backup, .ground_instant_backup,
    .ground_instant_dir_en, .ground_timed_backup, .ground_timed_dir_en,
    .ground_dir_forward, .fault_detector, .trip, .instant_trip, .timed_trip,
    .backup_trip, .reach_reset_contact, .reach_select_gate, .z4_reverse,
    .scheme_conflict);

  dzts_recl_model recl_u (.mclk, .cmd(rc_cmd), .initiate(recloser_initiate),
    .state(recloser_state), .contact_pin(recloser_contact_input));

  ////////////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up

  // One tick pulse per two cycles; outputs read at the falling edge
  task automatic do_ticks(input int n);
    repeat (n)
    begin
      @(posedge mclk) tick <= 1'b1;
      @(posedge mclk) tick <= 1'b0;
    end
    @(negedge mclk);
  endtask : do_ticks

  task automatic rc_go(input logic [1:0] c, input int n);
    @(posedge mclk);
    rc_cmd <= c;
    do_ticks(n);
  endtask : rc_go

  // No pickups, longest delays, so nothing trips by accident
  task automatic quiet;
    {zone_phase_en, zone_ground_en} <= 8'h00;
    {phase_meas, ground_meas} <= 24'h000000;
    {phase_delay, ground_delay} <= 24'hffffff;
    {phase_instant_backup, ground_instant_backup, ground_timed_backup} <= 3'h0;
    {ground_instant_dir_en, ground_timed_dir_en, ground_dir_forward} <= 3'h0;
    {z1_reactance_sel, z2_gdoc_trip, fault_detector} <= 3'h0;
    {z1_reactance_meas, z1_adaptive_mho} <= 6'h00;
    z2_gdoc_mode <= DZTS_GD_OFF;
  endtask : quiet

  task automatic idle(input string name);
    @(posedge mclk);
    quiet();
    do_ticks(2);
    $display("test %s done", name);
  endtask : idle

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_zone1;
    @(posedge mclk);
    zone_phase_en <= 4'h1;
    phase_meas[0] <= 3'h1;
    do_ticks(1);
    chk(instant_trip, 1'b1);
    chk(trip, 1'b0);
    @(posedge mclk);
    fault_detector <= 1'b1;
    scheme_sel <= DZTS_SCH_PILOT;
    do_ticks(1);
    chk(trip, 1'b1);
    @(posedge mclk);
    {zone_phase_en, zone_ground_en} <= 8'h01;
    ground_meas[0] <= 3'h4;
    do_ticks(1);
    chk(instant_trip, 1'b1);
    @(posedge mclk);
    zone_ground_en <= 4'h2;
    do_ticks(1);
    chk(instant_trip, 1'b0);
    idle("zone1");
  endtask : t_zone1

  // Zone 3 ground after 2 ticks, zone 2 phase after 3; ce low freezes all
  task automatic t_timer;
    @(posedge mclk);
    {zone_phase_en, zone_ground_en} <= 8'h24;
    phase_meas[1] <= 3'h1;
    ground_meas[2] <= 3'h2;
    phase_delay[0] <= 4'h2;
    ground_delay[1] <= 4'h1;
    {fault_detector, scheme_sel} <= {1'b1, DZTS_SCH_STEP};
    do_ticks(1);
    chk(timed_trip, 3'h0);
    do_ticks(1);
    chk(timed_trip, 3'h2);
    do_ticks(1);
    chk(timed_trip, 3'h3);
    chk(trip, 1'b1);
    @(posedge mclk);
    ce <= 1'b0;
    {phase_meas, ground_meas} <= 24'h000000;
    do_ticks(1);
    chk(timed_trip, 3'h3);
    @(posedge mclk);
    ce <= 1'b1;
    do_ticks(1);
    chk(timed_trip, 3'h0);
    idle("timer");
  endtask : t_timer

  task automatic t_ext;
    @(posedge mclk);
    {scheme_sel, recloser_internal, fault_detector} <= {DZTS_SCH_EXT, 2'h3};
    zone_phase_en <= 4'h3;
    phase_meas[1] <= 3'h2;
    phase_delay[0] <= 4'h2;
    do_ticks(1);
    chk(instant_trip, 1'b1);
    chk(reach_reset_contact, 1'b0);
    // Instant source follows the flag one tick after it sets
    rc_go(2'h1, 2);
    chk(reach_reset_contact, 1'b1);
    chk(reach_select_gate, 1'b1);
    chk(instant_trip, 1'b0);
    rc_go(2'h0, 1);
    chk(timed_trip, 3'h1);
    chk(trip, 1'b1);
    rc_go(2'h2, 2);
    chk(reach_reset_contact, 1'b1);
    rc_go(2'h3, 2);
    chk(reach_reset_contact, 1'b0);
    chk(instant_trip, 1'b1);
    idle("extension");
  endtask : t_ext

  // Momentary external contact, stretched by d ticks
  task automatic t_contact(input logic [TW-1:0] d);
    @(posedge mclk);
    {scheme_sel, recloser_internal, stretch_dropout} <= {DZTS_SCH_EXT, 1'b0, d};
    zone_phase_en <= 4'h2;
    phase_meas[1] <= 3'h1;
    do_ticks(1);
    chk(instant_trip, 1'b1);
    rc_go(2'h1, 2);
    rc_go(2'h0, 2);
    chk(reach_select_gate, 1'b1);
    chk(instant_trip, 1'b0);
    do_ticks(2);
    chk(reach_select_gate, d != 4'h0);
    do_ticks(6);
    chk(reach_select_gate, 1'b0);
    chk(instant_trip, 1'b1);
    idle("contact");
  endtask : t_contact

  // Backup inputs: phase, gnd inst, its dir, gnd timed, its dir, forward
  task automatic bk(input logic [5:0] v, input logic e);
    @(posedge mclk);
    {phase_instant_backup, ground_instant_backup, ground_instant_dir_en,
      ground_timed_backup, ground_timed_dir_en, ground_dir_forward} <= v;
    do_ticks(1);
    chk(backup_trip, e);
  endtask : bk

  task automatic gd(input dzts_gdoc_e m, input logic [2:0] g, input logic t, input logic e);
    @(posedge mclk);
    {z2_gdoc_mode, z2_gdoc_trip, ground_meas[1]} <= {m, t, g};
    do_ticks(1);
    chk(timed_trip, {2'h0, e});
  endtask : gd

  task automatic t_opts;
    @(posedge mclk);
    {scheme_sel, z4_reverse_set} <= {DZTS_SCH_PILOT, 1'b0};
    do_ticks(1);
    chk({z4_reverse, scheme_conflict}, 2'h1);
    @(posedge mclk);
    z4_reverse_set <= 1'b1;
    do_ticks(1);
    chk({z4_reverse, scheme_conflict}, 2'h2);
    @(posedge mclk);
    {scheme_sel, zone_ground_en, z1_reactance_sel} <= {DZTS_SCH_STEP, 4'h3, 1'b1};
    {ground_meas[0], z1_reactance_meas, z1_adaptive_mho} <= 9'h094;
    ground_delay[0] <= 4'h0;
    do_ticks(1);
    chk(instant_trip, 1'b0);
    @(posedge mclk);
    z1_adaptive_mho <= 3'h2;
    do_ticks(1);
    chk(instant_trip, 1'b1);
    gd(DZTS_GD_REPLACE, 3'h1, 1'b0, 1'b0);
    gd(DZTS_GD_REPLACE, 3'h0, 1'b1, 1'b1);
    gd(DZTS_GD_SUPPLEMENT, 3'h0, 1'b1, 1'b1);
    gd(DZTS_GD_SUPPLEMENT, 3'h1, 1'b0, 1'b1);
    gd(DZTS_GD_SPARE, 3'h1, 1'b0, 1'b1);
    gd(DZTS_GD_OFF, 3'h0, 1'b1, 1'b0);
    // Zero delay on the zone four phase timer operates at once
    @(posedge mclk);
    {zone_phase_en, phase_meas[3], phase_delay[2], fault_detector} <= {4'h8, 3'h1, 4'h0, 1'b1};
    do_ticks(1);
    chk(timed_trip, 3'h4);
    idle("options");
  endtask : t_opts

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard
  initial
  begin
    #100000;
    mismatches++;
    wrap_up();
  end

  initial
  begin
    mismatches = 0;
    check_count = 0;
    {rst_n, ce, tick, recloser_internal, z4_reverse_set} = 5'h0a;
    {rc_cmd, stretch_dropout} = 6'h00;
    scheme_sel = DZTS_SCH_STEP;
    quiet();
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    @(negedge mclk);
    chk({trip, reach_reset_contact, backup_trip}, 3'h0);
    t_zone1();
    t_timer();
    t_ext();
    t_contact(4'h3);
    t_contact(4'h0);
    bk(6'h20, 1'b1);
    bk(6'h18, 1'b0);
    bk(6'h19, 1'b1);
    bk(6'h10, 1'b1);
    bk(6'h06, 1'b0);
    bk(6'h07, 1'b1);
    bk(6'h04, 1'b1);
    idle("backup");
    t_opts();
    wrap_up();
  end
endmodule : testbench
